// *** adc_ctrl_pkg.sv ***
// constants and types for the converter register control block
`default_nettype none
package adc_ctrl_pkg;
    localparam logic [7:0] OFF_DIV     = 8'hf2;
    localparam logic [7:0] OFF_CTRL    = 8'hf3;
    localparam logic [7:0] OFF_RES_LO  = 8'hf4;
    localparam logic [7:0] OFF_RES_HI  = 8'hf5;
    localparam logic [7:0] OFF_PINSEL  = 8'hf6;
    localparam int BIT_PSEUDO_IDLE_BIT = 6;
    localparam int BIT_EN     = 5;
    localparam int BIT_EOC    = 4;
    localparam int BIT_START  = 3;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [4:0] DIV_RST    = 5'h00;
    localparam logic [9:0] RES_RST    = 10'h000;
    localparam logic [7:0] PINSEL_RST = 8'h00;
    localparam logic [5:0] DIV_ZERO_HALF = 6'h20; // 64 / 2
    localparam logic [3:0] CONV_CLOCKS   = 4'hb;  // 1 sample + 10 bits

    // control register fields
    typedef struct packed {
        logic       pseudo_idle_bit;
        logic       enable;
        logic       eoc;
        logic       start;
        logic [2:0] channel;
    } ctrl_t;

    // sfr bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b001,
        S_SAMPLE = 3'b010,
        S_BITS   = 3'b100
    } conv_state_t;
endpackage
`default_nettype wire

// *** adc_clk_gen.sv ***
// converter clock tick generator from the prescaler value
`timescale 1ns/1ps
`default_nettype none
module adc_clk_gen (
    // clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       NRST,
    // control
    input  wire logic       run,
    input  wire logic [4:0] div,
    // tick out
    output logic            tick
);
    import adc_ctrl_pkg::*;
    logic [5:0] cnt_q, cnt_d, half;
    logic       ph_q, ph_d, tick_d;

    // half period: div, or 32 when div is zero, giving /2*div or /64
    always_comb begin
        half   = (div == DIV_RST) ? DIV_ZERO_HALF : {1'b0, div};
        cnt_d  = cnt_q;
        ph_d   = ph_q;
        tick_d = 1'b0;
        if (!run) begin
            cnt_d = 6'h00;
            ph_d  = 1'b0;
        end else if (cnt_q + 6'h01 >= half) begin
            cnt_d  = 6'h00;
            ph_d   = ~ph_q;
            tick_d = ph_q; // one tick per full converter clock
        end else begin
            cnt_d = cnt_q + 6'h01;
        end
    end

    // counter registers
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_q <= 6'h00;
            ph_q  <= 1'b0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ph_q  <= ph_d;
            tick  <= tick_d;
        end
    end
endmodule // adc_clk_gen
`default_nettype wire

// *** adc_sfr_control.sv ***
// converter special function registers and conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_sfr_control (
    // clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   NRST,
    // sfr bus
    input  wire adc_ctrl_pkg::sfr_req_t SFR_REQ,
    output logic [7:0]                  SFR_RDATA,
    // interrupt enables from the interrupt controller and the request back to it
    input  wire logic                   CONV_IRQ_ENABLE,
    input  wire logic                   GLOBAL_IRQ_ENABLE,
    output logic                        CONV_IRQ,
    // analog core
    input  wire logic                   CORE_BIT,
    output logic [7:0]                  PIN_ANALOG,
    output logic [2:0]                  CORE_CHANNEL,
    output logic                        CORE_STANDBY_N,
    output logic                        CORE_SAMPLE,
    output logic                        CORE_STEP,
    output logic                        PSEUDO_IDLE
);
    import adc_ctrl_pkg::*;

    // register file
    ctrl_t       ctrl_q, ctrl_d;   // mode, enable, flag, start, channel
    logic [4:0]  div_q, div_d;     // prescaler value
    logic [7:0]  pins_q, pins_d;   // analog pin selection
    logic [9:0]  res_q, res_d;     // last finished result
    // sequencer
    logic [9:0]  sar_q, sar_d;     // decisions gathered msb first
    logic [3:0]  cnt_q, cnt_d;     // converter clocks used so far
    conv_state_t st_q, st_d;
    // comparator synchroniser
    logic        core_bit_s1_q, core_bit_s2_q;
    // internal strobes
    logic        tick, busy, done;
    // next values of the registered outputs
    logic [7:0]  rdata_d;
    logic        irq_d, samp_d, step_d;

    // a write strobe aimed at one register offset
    function automatic logic hit(input sfr_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // a start may run only with the converter on and its pin analog;
    // the sequencer and the start-bit clear both ask the same question
    function automatic logic start_ok(input ctrl_t c,
                                      input logic [7:0] p);
        start_ok = c.enable && p[c.channel];
    endfunction

    // converter clock ticks; the divider only runs while busy so each
    // conversion starts from a fresh phase
    adc_clk_gen adc_clk_gen_inst (
        .REF_CLK (REF_CLK),
        .NRST    (NRST),
        .run     (busy),
        .div     (div_q),
        .tick    (tick)
    );

    // the divider runs, and the core is sequenced, only outside idle
    assign busy = (st_q != S_IDLE);

    // conversion sequencer, paced by converter clock ticks
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sar_d  = sar_q;
        done   = 1'b0;
        samp_d = 1'b0;
        step_d = 1'b0;
        case (st_q)
            S_IDLE: begin
                // start only if enabled and channel pin is analog
                if (ctrl_q.start && start_ok(ctrl_q, pins_q)) begin
                    st_d  = S_SAMPLE;
                    cnt_d = 4'h0;
                end
            end
            S_SAMPLE: begin
                // hold the sample switch closed for one converter clock
                samp_d = 1'b1;
                if (tick) begin
                    st_d  = S_BITS;
                    cnt_d = 4'h1;
                end
            end
            S_BITS: begin
                if (tick) begin
                    step_d = 1'b1;
                    // one decision per tick, shifted in msb first
                    sar_d  = {sar_q[8:0], core_bit_s2_q};
                    if (cnt_q == CONV_CLOCKS - 4'h1) begin
                        st_d = S_IDLE;
                        done = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            // an illegal one-hot code falls back to idle
            default: st_d = S_IDLE;
        endcase
        // dropping enable aborts into standby
        // a partial result is thrown away, the flag stays as it was
        if (!ctrl_q.enable) begin
            st_d = S_IDLE;
            done = 1'b0;
        end
    end

    // register writes and hardware updates
    always_comb begin
        ctrl_d = ctrl_q;
        div_d  = div_q;
        pins_d = pins_q;
        res_d  = res_q;
        // bit 7 of a control write has no storage
        if (hit(SFR_REQ, OFF_CTRL))
            ctrl_d = ctrl_t'(SFR_REQ.wdata[6:0]);
        if (hit(SFR_REQ, OFF_DIV))
            div_d = SFR_REQ.wdata[4:0];
        if (hit(SFR_REQ, OFF_PINSEL))
            pins_d = SFR_REQ.wdata;
        // a start on a digital pin or while disabled is dropped
        if (st_q == S_IDLE && ctrl_q.start && !start_ok(ctrl_q, pins_q))
            ctrl_d.start = 1'b0;
        // conversion end: result, flag and start move on one edge, and a
        // flag clear written in the same cycle loses to the set
        if (done) begin
            res_d         = sar_d;
            ctrl_d.start  = 1'b0;
            ctrl_d.eoc    = 1'b1;   // set wins over clear
            ctrl_d.pseudo_idle_bit = 1'b0;   // wake from pseudo-idle
        end
    end

    // read mux, registered so the data comes straight from a flip-flop
    always_comb begin
        // reserved and unmapped bits read as zero
        case (SFR_REQ.addr)
            OFF_CTRL:   rdata_d = {1'b0, ctrl_d};
            OFF_DIV:    rdata_d = {3'h0, div_d};
            OFF_RES_HI: rdata_d = res_d[9:2];
            OFF_RES_LO: rdata_d = {6'h00, res_d[1:0]};
            OFF_PINSEL: rdata_d = pins_d;
            default:    rdata_d = 8'h00;
        endcase
        // request both local and global enable
        irq_d = ctrl_d.eoc && CONV_IRQ_ENABLE
                && GLOBAL_IRQ_ENABLE;
    end

    // sequencer registers
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q  <= S_IDLE;
            cnt_q <= 4'h0;
            sar_q <= RES_RST;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            sar_q <= sar_d;
        end
    end

    // comparator level is asynchronous to REF_CLK; only the second
    // stage feeds the shift register, the first may go metastable
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            core_bit_s1_q <= 1'b0;
            core_bit_s2_q <= 1'b0;
        end else begin
            core_bit_s1_q <= CORE_BIT;
            core_bit_s2_q <= core_bit_s1_q;
        end
    end

    // software visible registers
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q <= ctrl_t'(CTRL_RST[6:0]);
            div_q  <= DIV_RST;
            pins_q <= PINSEL_RST;
            res_q  <= RES_RST;
        end else begin
            ctrl_q <= ctrl_d;
            div_q  <= div_d;
            pins_q <= pins_d;
            res_q  <= res_d;
        end
    end

    // registered outputs; the register copies are built from next values so each moves on the
    // same edge as the register it mirrors; CORE_SAMPLE and CORE_STEP follow the state one edge later
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            SFR_RDATA      <= 8'h00;
            CONV_IRQ       <= 1'b0;
            PIN_ANALOG     <= PINSEL_RST;
            CORE_CHANNEL   <= 3'h0;
            CORE_STANDBY_N <= 1'b0;
            CORE_SAMPLE    <= 1'b0;
            CORE_STEP      <= 1'b0;
            PSEUDO_IDLE    <= 1'b0;
        end else begin
            SFR_RDATA      <= rdata_d;
            CONV_IRQ       <= irq_d;
            PIN_ANALOG     <= pins_d;
            CORE_CHANNEL   <= ctrl_d.channel;
            CORE_STANDBY_N <= ctrl_d.enable;
            CORE_SAMPLE    <= samp_d;
            CORE_STEP      <= step_d;
            PSEUDO_IDLE    <= ctrl_d.pseudo_idle_bit && ctrl_d.start;
        end
    end
endmodule // adc_sfr_control
`default_nettype wire

// *** adc_sfr_control_assertions.sv ***
// property checks for the converter register control block
`timescale 1ns/1ps
`default_nettype none
module adc_sfr_control_assertions (
    // clock and reset
    input wire logic                   REF_CLK,
    input wire logic                   NRST,
    // sfr bus
    input wire adc_ctrl_pkg::sfr_req_t SFR_REQ,
    input wire logic [7:0]             SFR_RDATA,
    // interrupt
    input wire logic                   CONV_IRQ_ENABLE,
    input wire logic                   GLOBAL_IRQ_ENABLE,
    input wire logic                   CONV_IRQ,
    // analog core
    input wire logic                   CORE_BIT,
    input wire logic [7:0]             PIN_ANALOG,
    input wire logic [2:0]             CORE_CHANNEL,
    input wire logic                   CORE_STANDBY_N,
    input wire logic                   CORE_SAMPLE,
    input wire logic                   CORE_STEP,
    input wire logic                   PSEUDO_IDLE
);
    import adc_ctrl_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // writes of interest; the copies move one edge after the write, the checks allow two
    wire wr_pin = SFR_REQ.wr && SFR_REQ.addr == OFF_PINSEL;
    wire wr_en  = SFR_REQ.wr && SFR_REQ.addr == OFF_CTRL
                  && SFR_REQ.wdata[BIT_EN];
    AST_PIN_COPY: assert property (!$stable(PIN_ANALOG) |->
        $past(wr_pin) || $past(wr_pin, 2)) else $error("pin bits moved");
    AST_WAKE: assert property ($rose(CORE_STANDBY_N) |->
        $past(wr_en) || $past(wr_en, 2)) else $error("woke unasked");
    AST_STEP_PHASE: assert property (CORE_STEP |-> !CORE_SAMPLE)
        else $error("step in sample");
    AST_STEP_GAP: assert property (CORE_STEP |=> !CORE_STEP)
        else $error("steps too close");
    AST_SAMPLE_LEN: assert property ($rose(CORE_SAMPLE) |->
        CORE_SAMPLE[*2]) else $error("sample too short");
    AST_SAMPLE_PIN: assert property (CORE_SAMPLE |->
        PIN_ANALOG[CORE_CHANNEL]) else $error("digital pin sampled");
    AST_IRQ_EN: assert property (CONV_IRQ |->
        $past(CONV_IRQ_ENABLE && GLOBAL_IRQ_ENABLE)) else $error("irq");
    AST_LO_RSV: assert property ($past(SFR_REQ.addr) == OFF_RES_LO
        |-> SFR_RDATA[7:2] == 6'h00) else $error("low byte upper");
    AST_DIV_RSV: assert property ($past(SFR_REQ.addr) == OFF_DIV
        |-> SFR_RDATA[7:5] == 3'h0) else $error("divider upper");
    // main scenarios reached
    cover property ($rose(CONV_IRQ));
    cover property ($rose(PSEUDO_IDLE));
    cover property ($rose(CORE_SAMPLE));
endmodule // adc_sfr_control_assertions
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the converter register control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_ctrl_pkg::*;
    logic       clk, nrst, cie, gie, irq, cbit, stn, smp, stp, psi;
    sfr_req_t   req;
    logic [7:0] rdata, pins;
    logic [2:0] chan;
    int         failures, checks_done, n;
    adc_sfr_control adc_sfr_control_inst (
        .REF_CLK(clk), .NRST(nrst), .SFR_REQ(req), .SFR_RDATA(rdata),
        .CONV_IRQ_ENABLE(cie), .GLOBAL_IRQ_ENABLE(gie), .CONV_IRQ(irq),
        .CORE_BIT(cbit), .PIN_ANALOG(pins), .CORE_CHANNEL(chan),
        .CORE_STANDBY_N(stn), .CORE_SAMPLE(smp), .CORE_STEP(stp),
        .PSEUDO_IDLE(psi));
    // 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic stop_test;
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // inputs move 1 ns after the edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [7:0] s, logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // idle cycle after each write so wr never toggles twice in a step
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        tick;
        req.wr = 1'b0;
        tick;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        req.addr = a;
        tick;
        chk(rdata, e);
    endtask
    // one conversion with a constant comparator level, then flag clear
    task automatic conv(logic [2:0] c, logic b, logic [7:0] cmd, int cy);
        int steps;
        steps = 0;
        cbit = b;
        wr(OFF_CTRL, cmd | {5'h00, c});
        chk(8'(chan), 8'(c));
        if (cmd[6])
            chk(8'(psi), 8'h01);
        n = 2;
        while (irq !== 1'b1 && n < 2000) begin
            tick;
            n++;
            if (stp === 1'b1)
                steps++;
        end
        if (n >= 2000) begin
            failures++;
            stop_test;
        end
        chk(8'(n >= cy && n <= cy + 8), 8'h01);
        chk(8'(steps), 8'h0a);
        rd(OFF_CTRL, 8'h30 | {5'h00, c});
        rd(OFF_RES_HI, {8{b}});
        rd(OFF_RES_LO, {6'h00, b, b});
        wr(OFF_CTRL, 8'h20 | {5'h00, c});
        chk(8'(irq), 8'h00);
    endtask
    initial begin
        failures = 0;
        checks_done = 0;
        req = '0;
        cie = 1'b1;
        gie = 1'b1;
        cbit = 1'b0;
        nrst = 1'b0;
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        tick;
        for (int a = 'hf2; a <= 'hf6; a++)
            rd(8'(a), 8'h00);
        wr(OFF_DIV, 8'h1f);
        rd(OFF_DIV, 8'h1f);
        wr(OFF_PINSEL, 8'h5a);
        rd(OFF_PINSEL, 8'h5a);
        chk(pins, 8'h5a);
        wr(OFF_PINSEL, 8'hff);
        wr(OFF_DIV, 8'h01);
        for (int c = 0; c < 8; c++)
            conv(3'(c), c[0], 8'h28, 22);
        // precision start as read-modify-write: clear channel, add it,
        // then set mode and start on top (0x23 | 0x48 = 0x68 | 3)
        rd(OFF_CTRL, 8'h27);
        wr(OFF_CTRL, rdata & 8'hf8);
        wr(OFF_CTRL, rdata | 8'h03);
        conv(3'h3, 1'b1, 8'h68, 22);
        // flag raised with the interrupt path closed, then opened
        gie = 1'b0;
        wr(OFF_CTRL, 8'h2a);
        repeat (30) tick;
        chk(8'(irq), 8'h00);
        rd(OFF_CTRL, 8'h32);
        cie = 1'b0;
        gie = 1'b1;
        tick;
        chk(8'(irq), 8'h00);
        cie = 1'b1;
        tick;
        chk(8'(irq), 8'h01);
        wr(OFF_CTRL, 8'h22);
        chk(8'(irq), 8'h00);
        wr(OFF_DIV, 8'h00);
        conv(3'h1, 1'b0, 8'h28, 704);
        wr(OFF_PINSEL, 8'hfd);
        wr(OFF_CTRL, 8'h29);
        repeat (4) tick;
        rd(OFF_CTRL, 8'h21);
        chk(8'(irq), 8'h00);
        wr(OFF_CTRL, 8'h08);
        repeat (4) tick;
        chk(8'(stn), 8'h00);
        rd(OFF_CTRL, 8'h00);
        stop_test;
    end
endmodule // tb_top
bind adc_sfr_control adc_sfr_control_assertions
    adc_sfr_control_assertions_inst (
    .REF_CLK(REF_CLK), .NRST(NRST), .SFR_REQ(SFR_REQ),
    .SFR_RDATA(SFR_RDATA), .CONV_IRQ_ENABLE(CONV_IRQ_ENABLE),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .CONV_IRQ(CONV_IRQ),
    .CORE_BIT(CORE_BIT), .PIN_ANALOG(PIN_ANALOG),
    .CORE_CHANNEL(CORE_CHANNEL), .CORE_STANDBY_N(CORE_STANDBY_N),
    .CORE_SAMPLE(CORE_SAMPLE), .CORE_STEP(CORE_STEP),
    .PSEUDO_IDLE(PSEUDO_IDLE));
`default_nettype wire
